// file: include/lcd_ctrl_pkg.sv
/*
  Shared constants and types for the graphic LCD controller core: display
  geometry, command byte fields, serial bus address and receiver states.
  Assumes a single 100 MHz system clock standing in for the oscillator.
*/
package lcd_ctrl_pkg;

  // Display geometry.
  localparam int unsigned ROWS       = 40;   // Multiplexed row outputs.
  localparam int unsigned COLS       = 101;  // Column outputs, one per column address.
  localparam int unsigned BANKS      = 5;    // Banks of eight rows each.
  localparam logic [6:0]  COL_LAST   = 7'h64; // Highest legal column address (100).
  localparam logic [2:0]  BANK_LAST  = 3'h4;  // Highest legal bank address.

  // Frame timing: one frame is this many clock cycles.
  localparam int unsigned FRAME_CYCLES = 3072;
  localparam logic [11:0] FRAME_MOD    = 12'hC00; // FRAME_CYCLES at accumulator width.
  localparam logic [11:0] ROW_STEP     = 12'h028; // ROWS at accumulator width.
  localparam logic [5:0]  ROW_LAST     = 6'h27;   // Index of the last row.

  // Synchronous power-on reset length in clock cycles.
  localparam logic [1:0]  POR_CYCLES = 2'h2;

  // Command byte field positions.
  localparam int unsigned CONT_BIT  = 7;  // Continuation: more command bytes follow.
  localparam int unsigned MODE_HI   = 6;  // Upper display status bit.
  localparam int unsigned MODE_LO   = 5;  // Lower display status bit.
  localparam int unsigned SLEEP_BIT = 4;  // Power-down request.
  localparam int unsigned VERT_BIT  = 3;  // Vertical addressing when set.

  // Serial bus slave address, upper six bits; the low bit is a pin.
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1E;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Display status encodings (upper bit first).
  typedef enum logic [1:0] {
    MODE_BLANK   = 2'h0,
    MODE_INVERSE = 2'h1,
    MODE_ALL_ON  = 2'h2,
    MODE_NORMAL  = 2'h3
  } disp_mode_t;

  // Serial byte receiver states.
  typedef enum {
    RX_IDLE,
    RX_BITS,
    RX_ACK
  } rx_state_t;

endpackage

// file: rtl/serial_byte_rx.sv
/*
  Write-only two-wire serial bus slave receiver. Detects start and stop,
  matches the slave address, acknowledges and hands each byte after the
  address to the core as a one-cycle strobe at the start of its acknowledge.
  Assumes bus pins are asynchronous to clk_sys and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_byte_rx (
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                hold,
  // Bus pins.
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  input  wire logic                slaveIdLow,
  // Core side.
  output logic                     startPulse,
  output logic                     byteStrobe,
  output logic [7:0]               byteData
);
  import lcd_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and later are looked at.
  logic [1:0] sclSync_q;    // Two-flop synchroniser for the clock pin.
  logic [1:0] sdaSync_q;    // Two-flop synchroniser for the data pin.
  logic       sclPrev_q;    // Previous synchronised clock level.
  logic       sdaPrev_q;    // Previous synchronised data level.
  logic [1:0] idSync_q;     // Synchronised slave address low pin.

  // Every pin passes two flops before any decision is made on it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      idSync_q  <= 2'h0;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
      idSync_q  <= {idSync_q[0], slaveIdLow};
    end
  end

  logic sclRise;   // Bus clock rising edge.
  logic sclFall;   // Bus clock falling edge.
  logic startCond; // Data falls while clock high.
  logic stopCond;  // Data rises while clock high.
  assign sclRise   = sclSync_q[1] & ~sclPrev_q;
  assign sclFall   = ~sclSync_q[1] & sclPrev_q;
  assign startCond = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
  assign stopCond  = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Receiver state machine.
  rx_state_t  state_q;     // Current receiver state.
  logic [3:0] bitCnt_q;    // Bits taken in the current byte.
  logic [7:0] shift_q;     // Incoming byte, MSB first.
  logic       isAddr_q;    // Current byte is the slave address.

  // Start restarts the transfer anywhere; stop or a foreign address idles.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q    <= RX_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      isAddr_q   <= 1'b0;
      sdaOe      <= 1'b0;
      sdaOut     <= 1'b0;
      startPulse <= 1'b0;
      byteStrobe <= 1'b0;
      byteData   <= 8'h00;
    end else begin
      startPulse <= 1'b0;
      byteStrobe <= 1'b0;
      if (hold || stopCond) begin
        // Held in reset until the core's power-on reset completes.
        state_q <= RX_IDLE;
        sdaOe   <= 1'b0;
      end else if (startCond) begin
        state_q    <= RX_BITS;
        bitCnt_q   <= 4'h0;
        isAddr_q   <= 1'b1;
        sdaOe      <= 1'b0;
        startPulse <= 1'b1;
      end else begin
        case (state_q)
          RX_BITS: begin
            if (sclRise && bitCnt_q != BITS_PER_BYTE) begin
              shift_q  <= {shift_q[6:0], sdaSync_q[1]};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
              if (isAddr_q) begin
                // Only write transfers to our address are acknowledged.
                if (shift_q == {SLAVE_ADDR_HI, idSync_q[1], 1'b0}) begin
                  sdaOe   <= 1'b1;
                  state_q <= RX_ACK;
                end else begin
                  state_q <= RX_IDLE;
                end
              end else begin
                // Byte is handed over as the acknowledge begins.
                byteData   <= shift_q;
                byteStrobe <= 1'b1;
                sdaOe      <= 1'b1;
                state_q    <= RX_ACK;
              end
            end
          end
          RX_ACK: begin
            if (sclFall) begin
              sdaOe    <= 1'b0;
              isAddr_q <= 1'b0;
              bitCnt_q <= 4'h0;
              state_q  <= RX_BITS;
            end
          end
          default: begin
            state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/lcd_ctrl_core.sv
/*
  Digital core of a 40 by 101 dot-matrix LCD controller. Takes command and
  display bytes from the serial receiver, keeps display mode, sleep and the
  write pointer, stores bytes in display memory and scans it row by row.
  Assumes clk_sys stands for the oscillator or the external clock pin.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - One frame spans 3072 clock cycles.
// - Synchronous reset completes after two clock cycles.
// - Sleep stops oscillator, bias; outputs tied high.
// - Memory and state kept through sleep.
// - Commands and writes still work while sleeping.
// - One 8-bit register shared by commands, data.
// - No read-back path exists.
// - Bank from control byte, column from address.
// - Pointer advances per byte, direction flag chooses.
// - Memory is five banks of 101 bytes.
// - Column address maps to same column output.
// - Two status bits select display mode.
// - Rows refreshed one at a time, 40 rows.
// - Refresh never disturbed by bus writes.
// - Column addresses span 0 to 100.
// - Commands execute during the acknowledge cycle.
// - After reset the device sleeps.
module lcd_ctrl_core (
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Serial bus pins.
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  input  wire logic                slaveIdLowPin,
  // Panel drive, high means the output is tied to the positive supply.
  output logic [lcd_ctrl_pkg::ROWS-1:0] rowDrive_q,
  output logic [lcd_ctrl_pkg::COLS-1:0] colDrive_q,
  // Analogue controls.
  output logic                     oscRun_q,
  output logic                     biasOn_q,
  output logic                     sleepFlag_q
);
  import lcd_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset sequencer.
  logic [1:0] porCnt_q;  // Cycles of synchronous reset done so far.
  logic       porDone;   // Synchronous reset finished.
  assign porDone = (porCnt_q == POR_CYCLES);

  // Counts two clock edges after release; with no clock it never completes,
  // which is why oscRun_q is held high from reset until these edges are counted.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      porCnt_q <= 2'h0;
    end else if (!porDone) begin
      porCnt_q <= porCnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver: one holding register feeds both command and data paths.
  logic       startPulse;  // A start condition was seen.
  logic       byteStrobe;  // A byte is in the holding register.
  logic [7:0] holdReg;     // Shared command or display byte.

  serial_byte_rx u_rx (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .hold       (!porDone),
    .sclIn      (sclIn),
    .sdaIn      (sdaIn),
    .sdaOut     (sdaOut),
    .sdaOe      (sdaOe),
    .slaveIdLow (slaveIdLowPin),
    .startPulse (startPulse),
    .byteStrobe (byteStrobe),
    .byteData   (holdReg)
  );

  // Step with wrap; used for both the column and the bank parts.
  function automatic logic [6:0] wrapInc(input logic [6:0] v, input logic [6:0] top);
    wrapInc = (v >= top) ? 7'h00 : v + 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and write pointer.
  logic       cmdPhase_q;   // Bytes are commands until continuation clears.
  logic       expectCol_q;  // Next command byte is the column address.
  logic       vertical_q;   // Vertical addressing selected.
  disp_mode_t mode_q;       // Display status.
  logic [2:0] bankPtr_q;    // Bank part of the write pointer.
  logic [6:0] colPtr_q;     // Column part of the write pointer.
  logic       wrEn;         // Display byte to store this cycle.
  logic       colWrap;      // Column part is at its last address.
  logic       bankWrap;     // Bank part is at its last address.

  assign wrEn     = byteStrobe && !cmdPhase_q;
  assign colWrap  = (colPtr_q >= COL_LAST);
  assign bankWrap = (bankPtr_q >= BANK_LAST);

  // Commands act in the cycle the byte strobe arrives, sleeping or not;
  // nothing here is cleared by sleep, so all settings survive it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmdPhase_q  <= 1'b1;
      expectCol_q <= 1'b0;
      vertical_q  <= 1'b0;
      mode_q      <= MODE_BLANK;
      sleepFlag_q <= 1'b1;
      bankPtr_q   <= 3'h0;
      colPtr_q    <= 7'h00;
    end else if (!porDone) begin
      sleepFlag_q <= 1'b1;
    end else if (startPulse) begin
      cmdPhase_q  <= 1'b1;
      expectCol_q <= 1'b0;
    end else if (byteStrobe) begin
      if (cmdPhase_q) begin
        if (!expectCol_q) begin
          mode_q      <= disp_mode_t'(holdReg[MODE_HI:MODE_LO]);
          sleepFlag_q <= holdReg[SLEEP_BIT];
          vertical_q  <= holdReg[VERT_BIT];
          // Banks above the last are folded back to bank zero.
          bankPtr_q   <= (holdReg[2:0] > BANK_LAST) ? 3'h0 : holdReg[2:0];
        end else begin
          // Out-of-range columns are folded back to column zero.
          colPtr_q    <= (holdReg[6:0] > COL_LAST) ? 7'h00 : holdReg[6:0];
        end
        expectCol_q <= !expectCol_q;
        cmdPhase_q  <= holdReg[CONT_BIT];
      end else if (vertical_q) begin
        // Vertical: bank first, then the next column.
        bankPtr_q <= 3'(wrapInc({4'h0, bankPtr_q}, {4'h0, BANK_LAST}));
        if (bankWrap) begin
          colPtr_q <= wrapInc(colPtr_q, COL_LAST);
        end
      end else begin
        // Horizontal: column first, then the next bank.
        colPtr_q <= wrapInc(colPtr_q, COL_LAST);
        if (colWrap) begin
          bankPtr_q <= 3'(wrapInc({4'h0, bankPtr_q}, {4'h0, BANK_LAST}));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display memory, no reset: contents are undefined after power-on.
  logic [7:0] dispMem [BANKS][COLS];

  // Writes take the pointer as it stood when the byte arrived.
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      dispMem[bankPtr_q][colPtr_q] <= holdReg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Row timing: 40 row steps spread evenly over a 3072-cycle frame.
  logic [11:0] rowAcc_q;  // Fractional row timer.
  logic [5:0]  row_q;     // Row being driven.
  logic        rowStep;   // Move to the next row this cycle.
  logic [11:0] accSum;    // Timer plus one step.

  assign accSum  = rowAcc_q + ROW_STEP;
  assign rowStep = (accSum >= FRAME_MOD);

  // The scan runs from the clock alone; bus activity never touches it.
  // Since 3072 is not a multiple of 40, every five row periods are four of 77 and one of 76.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rowAcc_q <= 12'h000;
      row_q    <= 6'h00;
    end else begin
      rowAcc_q <= rowStep ? accSum - FRAME_MOD : accSum;
      if (rowStep) begin
        row_q <= (row_q == ROW_LAST) ? 6'h00 : row_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column data for the current row, shaped by the display status.
  logic [2:0]      scanBank;  // Bank holding the current row.
  logic [2:0]      scanBit;   // Bit of the byte for that row.
  logic [COLS-1:0] rawCols;   // Memory bits of the current row.
  logic [COLS-1:0] modeCols;  // Columns after the display status.

  assign scanBank = row_q[5:3];
  assign scanBit  = row_q[2:0];

  // Column address n drives column output n.
  for (genvar c = 0; c < COLS; c++) begin : g_col
    assign rawCols[c] = dispMem[scanBank][c][scanBit];
  end

  // Display status decode.
  always_comb begin
    case (mode_q)
      MODE_BLANK:   modeCols = '0;
      MODE_NORMAL:  modeCols = rawCols;
      MODE_ALL_ON:  modeCols = '1;
      MODE_INVERSE: modeCols = ~rawCols;
      default:      modeCols = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers; sleep parks every row and column output high.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rowDrive_q <= '1;
      colDrive_q <= '1;
      oscRun_q   <= 1'b1;
      biasOn_q   <= 1'b0;
    end else if (sleepFlag_q) begin
      // The clock may only be halted from here on.
      rowDrive_q <= '1;
      colDrive_q <= '1;
      oscRun_q   <= !porDone;
      biasOn_q   <= 1'b0;
    end else begin
      // Active row is a single low; others sit high.
      for (int r = 0; r < ROWS; r++) begin
        rowDrive_q[r] <= (row_q != r[5:0]);
      end
      colDrive_q <= modeCols;
      oscRun_q   <= 1'b1;
      biasOn_q   <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: bench/bus_master_model.sv
/*
  Serial bus master model that writes to the controller.
  Assumes pull-ups on both lines and clk_sys as its time base.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // Time base and the wired data line.
  input  wire logic clk_sys,
  input  wire logic sdaWire,
  // Driven lines; a 1 means released to the pull-up.
  output logic      sclDrv,
  output logic      sdaDrv
);
  localparam int Q = 10; // Quarter bit in clk_sys cycles.

  // Idle bus: both lines released.
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  // Every change lands just after a clock edge.
  task automatic qw();
    repeat (Q) @(posedge clk_sys);
  endtask

  // Start, also usable as a repeated start.
  task automatic start();
    qw();
    sdaDrv <= 1'b1;
    qw();
    sclDrv <= 1'b1;
    qw();
    sdaDrv <= 1'b0;
    qw();
    sclDrv <= 1'b0;
  endtask

  // Eight bits, upper first, then a released ninth bit that reads the acknowledge.
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      qw();
      sdaDrv <= (i == 0) ? 1'b1 : b[i-1];
      qw();
      sclDrv <= 1'b1;
      qw();
      ack = !sdaWire;
      qw();
      sclDrv <= 1'b0;
    end
  endtask

  // Stop leaves both lines released.
  task automatic stop();
    qw();
    sdaDrv <= 1'b0;
    qw();
    sclDrv <= 1'b1;
    qw();
    sdaDrv <= 1'b1;
    qw();
  endtask
endmodule
`default_nettype wire

// file: bench/lcd_ctrl_monitor.sv
/*
  Checker for the controller core ports, bound to lcd_ctrl_core.
  Assumes one clock domain with rst asynchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_monitor (
  input wire logic                            clk_sys,
  input wire logic                            rst,
  input wire logic                            sclIn,
  input wire logic                            sdaIn,
  input wire logic                            sdaOut,
  input wire logic                            sdaOe,
  input wire logic                            slaveIdLowPin,
  input wire logic [lcd_ctrl_pkg::ROWS-1:0]   rowDrive_q,
  input wire logic [lcd_ctrl_pkg::COLS-1:0]   colDrive_q,
  input wire logic                            oscRun_q,
  input wire logic                            biasOn_q,
  input wire logic                            sleepFlag_q
);
  import lcd_ctrl_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [2:0]  porCnt_q;    // Edges since reset, saturating.
  logic        row39Prev_q; // Last row seen one cycle ago.
  logic [12:0] frameCnt_q;  // Cycles since the true frame start.
  logic        frameStart;  // First cycle of row 0 after row 39.
  assign frameStart = !rowDrive_q[0] && !row39Prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Helper counters; the frame count restarts on sleep since a wake lands mid-frame.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) porCnt_q <= 3'h0;
    else if (porCnt_q != 3'h7) porCnt_q <= porCnt_q + 3'h1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) row39Prev_q <= 1'b1;
    else row39Prev_q <= rowDrive_q[39];
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) frameCnt_q <= 13'h0000;
    else if (sleepFlag_q) frameCnt_q <= 13'h0000;
    else if (frameStart) frameCnt_q <= 13'h0001;
    else if (frameCnt_q != 13'h0000) frameCnt_q <= frameCnt_q + 13'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge is raised with the bus clock low and then held.
  sequence ackHeld;
    !sclIn ##0 sdaOe [*8];
  endsequence

  a_reset_sleeps: assert property ($past(rst) |-> sleepFlag_q && oscRun_q)
    else $error("not sleeping with oscillator on after reset");
  a_sleep_outputs_high: assert property (sleepFlag_q && $past(sleepFlag_q) |-> (&rowDrive_q) && (&colDrive_q) && !biasOn_q)
    else $error("outputs not tied high while sleeping");
  a_sleep_osc_off: assert property (porCnt_q == 3'h7 && sleepFlag_q && $past(sleepFlag_q) |-> !oscRun_q)
    else $error("oscillator running while sleeping");
  a_awake_bias_on: assert property (!sleepFlag_q && !$past(sleepFlag_q) |-> biasOn_q && oscRun_q)
    else $error("bias or oscillator off while awake");
  a_one_row_active: assert property (!sleepFlag_q && !$past(sleepFlag_q) && !$past(sleepFlag_q, 2) |-> $onehot(~rowDrive_q))
    else $error("not exactly one row active");
  a_frame_length: assert property (frameStart && frameCnt_q != 13'h0000 |-> frameCnt_q == 13'hC00)
    else $error("frame length wrong");
  a_ack_held: assert property ($rose(sdaOe) |-> ackHeld)
    else $error("acknowledge not held from a low bus clock");
  a_ack_release: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("acknowledge released with bus clock high");
  a_sda_pull_only: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
endmodule

bind lcd_ctrl_core lcd_ctrl_monitor mon (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveIdLowPin(slaveIdLowPin), .rowDrive_q(rowDrive_q),
  .colDrive_q(colDrive_q), .oscRun_q(oscRun_q), .biasOn_q(biasOn_q), .sleepFlag_q(sleepFlag_q));
`default_nettype wire

// file: bench/test_graphic_lcd_controller_core.sv
/*
  Self-checking bench for lcd_ctrl_core with a queue-fed display model.
  Assumes bus_master_model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_graphic_lcd_controller_core;
  import lcd_ctrl_pkg::*;
  logic            clk_sys = 1'b0;
  logic            rst     = 1'b1;
  logic            idLow   = 1'b0;
  logic            sclDrv, sdaDrv, sdaOut, sdaOe, oscRun_q, biasOn_q, sleepFlag_q;
  logic [ROWS-1:0] rowDrive_q;
  logic [COLS-1:0] colDrive_q;
  wire logic       sdaWire = sdaDrv & ~(sdaOe & ~sdaOut); // Open drain with pull-up.
  int              errors = 0, checks_done = 0, bank = 0, col = 0;
  logic [7:0]      mem [BANKS][COLS]; // Model of display memory.
  bit              known [BANKS][COLS];
  logic [1:0]      mode = 2'b00;
  logic            sleepExp = 1'b1, vert = 1'b0;
  logic [7:0]      adr, q[$];
  time             t0;

  lcd_ctrl_core dut (.clk_sys(clk_sys), .rst(rst), .sclIn(sclDrv), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .slaveIdLowPin(idLow), .rowDrive_q(rowDrive_q), .colDrive_q(colDrive_q),
    .oscRun_q(oscRun_q), .biasOn_q(biasOn_q), .sleepFlag_q(sleepFlag_q));
  bus_master_model master (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclDrv(sclDrv), .sdaDrv(sdaDrv));

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    checks_done++;
    // An unknown result counts as a mismatch, never as a pass.
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Pointer advance; a wrap in one direction carries into the other.
  task automatic step();
    if (vert) bank++;
    else col++;
    if (bank == BANKS) begin
      bank = 0;
      col++;
    end
    if (col == COLS) begin
      col = 0;
      if (!vert) bank = (bank + 1) % BANKS;
    end
  endtask

  // One write transfer; the model parses control, column and data bytes.
  task automatic xfer();
    logic ack, cmd, ctl;
    cmd = 1'b1;
    ctl = 1'b1;
    master.start();
    master.send(adr, ack);
    check(ack === (adr == {SLAVE_ADDR_HI, idLow, 1'b0}), "address acknowledge");
    if (ack) foreach (q[i]) begin
      master.send(q[i], ack);
      check(ack === 1'b1, "byte acknowledge");
      if (!cmd) begin
        mem[bank][col] = q[i];
        known[bank][col] = 1'b1;
        step();
      end else if (ctl) begin
        {mode, sleepExp, vert} = q[i][6:3];
        bank = q[i][2:0];
      end else col = q[i][6:0];
      if (cmd) ctl = !ctl;
      cmd = cmd & q[i][7];
    end
    master.stop();
    repeat (4) @(posedge clk_sys);
    check(sleepFlag_q === sleepExp, "sleep flag");
  endtask

  // Wait for row r and compare known columns (all in blank and all-on) against the model after the mode.
  task automatic check_row(input int r);
    logic e;
    int   bad, n;
    bad = 0;
    n = 0;
    // Let a row already in progress pass, so the compare falls well inside a fresh row.
    while (rowDrive_q[r] === 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    while (rowDrive_q[r] !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    for (int c = 0; c < COLS; c++) begin
      e = mem[r/8][c][r%8];
      case (mode)
        2'b00: e = 1'b0;
        2'b10: e = 1'b1;
        2'b01: e = ~e;
        default: ;
      endcase
      if ((known[r/8][c] || !mode[0]) && colDrive_q[c] !== e) bad++;
    end
    check(n < 4000 && bad == 0, "row contents");
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(3551));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    idLow <= 1'($urandom_range(1));
    repeat (8) @(posedge clk_sys);
    check(sleepFlag_q === 1'b1 && (&rowDrive_q) === 1'b1 && (&colDrive_q) === 1'b1, "reset state");
    check(biasOn_q === 1'b0 && oscRun_q === 1'b0, "reset analogue");
    adr = {SLAVE_ADDR_HI, ~idLow, 1'b0};
    q = {};
    xfer();
    adr = {SLAVE_ADDR_HI, idLow, 1'b0};
    q = {8'hE2, 8'h05, 8'($urandom), 8'($urandom), 8'($urandom)};
    xfer();
    check(biasOn_q === 1'b1 && oscRun_q === 1'b1, "awake analogue");
    check_row(16);
    check_row(23);
    q = {8'hEC, 8'h64, 8'($urandom), 8'($urandom)};
    xfer();
    check_row(32);
    check_row(0);
    for (int m = 0; m < 4; m++) begin
      q = {8'({1'b0, 2'(m), 5'h00})};
      xfer();
      check_row(m);
    end
    q = {8'hF0, 8'h0A, 8'($urandom), 8'($urandom)};
    xfer();
    check((&rowDrive_q) === 1'b1 && (&colDrive_q) === 1'b1 && biasOn_q === 1'b0, "sleep outputs");
    check(oscRun_q === 1'b0, "sleep oscillator");
    q = {8'h60};
    xfer();
    check_row(0);
    check_row(16);
    @(negedge rowDrive_q[0]);
    t0 = $time;
    @(negedge rowDrive_q[0]);
    check(($time - t0) == 30720, "frame period");
    results();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (95000) @(posedge clk_sys);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
